// ---- design/mcjd_cfg.svh ----
`ifndef MCJD_CFG_SVH
`define MCJD_CFG_SVH

// ==========================================================================
// Instruction field layout
`define MCJD_INSTR_W 16
`define MCJD_OFF_LSB 0
`define MCJD_OFF_W 5
`define MCJD_SEL_LSB 5
`define MCJD_SEL_W 6
`define MCJD_CREL_OPC_LSB 11
`define MCJD_CREL_OPC 5'h00
`define MCJD_IDF_OPC_LSB 5
`define MCJD_IDF_OPC 11'h1CC
`define MCJD_IDF_TEST_BIT 4
`define MCJD_IDF_JREG_BIT 3
`define MCJD_IDF_TAIL 3'h5
`define MCJD_IDR_OPC_LSB 6
`define MCJD_IDR_OPC 10'h0BD
`define MCJD_IDR_TEST_BIT 5

// ==========================================================================
// Branch test select codes
`define MCJD_C_FLAG_LO 6'h00
`define MCJD_C_FLAG_HI 6'h10
`define MCJD_C_TC 6'h20
`define MCJD_C_START_LO 6'h24
`define MCJD_C_START_HI 6'h25
`define MCJD_C_SCV_LO 6'h26
`define MCJD_C_SCS_LO 6'h29
`define MCJD_C_SCV_HI 6'h2C
`define MCJD_C_ALU_DONE 6'h2F
`define MCJD_C_BOOST_HI 6'h30
`define MCJD_C_BOOST_LO 6'h31
`define MCJD_C_CUR_HI 6'h32
`define MCJD_C_CUR_LO 6'h38
`define MCJD_C_OWN_HI 6'h3E
`define MCJD_C_OWN_LO 6'h3F

// ==========================================================================
// Source counts and reset values
`define MCJD_NUM_FLAGS 16
`define MCJD_NUM_TC 4
`define MCJD_NUM_SC 3
`define MCJD_NUM_CUR 6
`define MCJD_ADDR_W 10
`define MCJD_PC_RST 1'b0

`endif

// ---- design/mcjd_cond_mux.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcjd_cfg.svh"

module mcjd_cond_mux
	import mcjd_pkg::*;
(
	input wire mcjd_sel_t i_sel,
	input wire logic [15:0] i_flag,
	input wire logic [3:0] i_terminal_count,
	input wire logic i_start,
	input wire logic [2:0] i_shortcut_drain,
	input wire logic [2:0] i_shortcut_source,
	input wire logic i_alu_done,
	input wire logic i_boost_voltage,
	input wire logic [5:0] i_current_fb,
	input wire logic i_own_current_fb,
	output logic o_cond
);
	logic [63:0] cond_vec;

	// ======================================================================
	// Condition table, one entry per select code
	genvar g;
	generate
		for (g = 0; g < 16; g++) begin : g_tab
			assign cond_vec[`MCJD_C_FLAG_LO + g] = ~i_flag[g];
			assign cond_vec[`MCJD_C_FLAG_HI + g] = i_flag[g];
			if (g < `MCJD_NUM_TC) begin : g_tc
				assign cond_vec[`MCJD_C_TC + g] = i_terminal_count[g];
			end
			if (g < `MCJD_NUM_SC) begin : g_sc
				assign cond_vec[`MCJD_C_SCV_LO + g] = ~i_shortcut_drain[g];
				assign cond_vec[`MCJD_C_SCS_LO + g] = ~i_shortcut_source[g];
				assign cond_vec[`MCJD_C_SCV_HI + g] = i_shortcut_drain[g];
			end
			if (g < `MCJD_NUM_CUR) begin : g_cur
				assign cond_vec[`MCJD_C_CUR_HI + g] = i_current_fb[g];
				assign cond_vec[`MCJD_C_CUR_LO + g] = ~i_current_fb[g];
			end
		end
	endgenerate

	assign cond_vec[`MCJD_C_START_LO] = ~i_start;
	assign cond_vec[`MCJD_C_START_HI] = i_start;
	assign cond_vec[`MCJD_C_ALU_DONE] = i_alu_done;
	assign cond_vec[`MCJD_C_BOOST_HI] = i_boost_voltage;
	assign cond_vec[`MCJD_C_BOOST_LO] = ~i_boost_voltage;
	assign cond_vec[`MCJD_C_OWN_HI] = i_own_current_fb;
	assign cond_vec[`MCJD_C_OWN_LO] = ~i_own_current_fb;

	assign o_cond = cond_vec[i_sel];
endmodule

`default_nettype wire

// ---- design/mcjd_decode.sv ----
// Overview of operation
// - Relative conditional jump loads the PC with the relative target when its test holds.
// - Relative target is instruction address plus signed 5-bit offset, -16 to 15.
// - Select codes 0x00-0x0F test flags low, 0x10-0x1F test flags high.
// - Codes 0x20-0x23 terminal counts, 0x24/0x25 start low/high, 0x26-0x28 drain low.
// - Codes 0x29-0x2B test source feedback low, 0x2C-0x2E drain feedback high.
// - Code 0x2F tests that the arithmetic unit finished the issued request.
// - Codes 0x30/0x31 boost high/low, 0x32-0x37 currents high, 0x38-0x3D low.
// - Code 0x3E tests own current feedback high, 0x3F tests it low.
// - Relative conditional jump has bits 15:11 zero, select 10:5, offset 4:0.
// - Far core jump loads the PC from the selected jump register when test holds.
// - One selector bit picks a jump register holding any absolute address.
// - Core test value 0 matches core 0, value 1 matches core 1.
// - Far core jump: bits 15:5 00111001100, test bit 4, register bit 3, tail 101.
// - Relative core jump goes to instruction address plus signed offset when test holds.
// - Relative core jump: bits 15:6 0010111101, test bit 5, offset 4:0.
`timescale 1ns/1ps
`default_nettype none
`include "mcjd_cfg.svh"

module mcjd_decode
	import mcjd_pkg::*;
#(
	parameter int ADDR_W = `MCJD_ADDR_W
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_clk_en,
	input wire logic i_instr_valid,
	input wire logic [15:0] i_instr,
	input wire logic [ADDR_W-1:0] i_instr_addr,
	input wire logic i_core_id,
	input wire logic [ADDR_W-1:0] i_jump_reg_zero,
	input wire logic [ADDR_W-1:0] i_jump_reg_one,
	input wire logic [15:0] i_flag,
	input wire logic [3:0] i_terminal_count,
	input wire logic i_start,
	input wire logic [2:0] i_shortcut_drain,
	input wire logic [2:0] i_shortcut_source,
	input wire logic i_alu_done,
	input wire logic i_boost_voltage,
	input wire logic [5:0] i_current_fb,
	input wire logic i_own_current_fb,
	output logic o_pc_load,
	output logic [ADDR_W-1:0] o_next_pc,
	output logic o_jump_taken,
	output logic o_decoded,
	output logic o_cond_met
);
	// ======================================================================
	// Field extraction
	mcjd_kind_t kind;
	mcjd_sel_t sel;
	logic [4:0] offset;
	logic [ADDR_W-1:0] rel_target;
	logic [ADDR_W-1:0] seq_target;
	logic [ADDR_W-1:0] far_target;
	logic cond_sel;
	logic idf_match;
	logic idr_match;
	logic accept;
	logic next_taken;
	logic next_cond;
	logic [ADDR_W-1:0] next_pc;

	assign accept = i_clk_en && i_instr_valid;
	assign sel = i_instr[`MCJD_SEL_LSB +: `MCJD_SEL_W];
	assign offset = i_instr[`MCJD_OFF_LSB +: `MCJD_OFF_W];

	// The offset is sign-extended so that backward loops wrap correctly.
	assign rel_target = i_instr_addr + {{(ADDR_W-5){offset[4]}}, offset};
	assign seq_target = i_instr_addr + ADDR_W'(1);
	// The selected register is used whole: any absolute address is reachable.
	assign far_target = i_instr[`MCJD_IDF_JREG_BIT] ? i_jump_reg_one : i_jump_reg_zero;

	// ======================================================================
	// Opcode decode
	always_comb begin
		if (i_instr[15:`MCJD_CREL_OPC_LSB] == `MCJD_CREL_OPC) begin
			kind = MCJD_KIND_CREL;
		end else if (i_instr[15:`MCJD_IDF_OPC_LSB] == `MCJD_IDF_OPC &&
				i_instr[2:0] == `MCJD_IDF_TAIL) begin
			kind = MCJD_KIND_IDF;
		end else if (i_instr[15:`MCJD_IDR_OPC_LSB] == `MCJD_IDR_OPC) begin
			kind = MCJD_KIND_IDR;
		end else begin
			kind = MCJD_KIND_NONE;
		end
	end

	// ======================================================================
	// Condition evaluation
	mcjd_cond_mux u_mux (
		.i_sel(sel),
		.i_flag(i_flag),
		.i_terminal_count(i_terminal_count),
		.i_start(i_start),
		.i_shortcut_drain(i_shortcut_drain),
		.i_shortcut_source(i_shortcut_source),
		.i_alu_done(i_alu_done),
		.i_boost_voltage(i_boost_voltage),
		.i_current_fb(i_current_fb),
		.i_own_current_fb(i_own_current_fb),
		.o_cond(cond_sel)
	);

	// Core identity: the test bit must equal the number of the executing core.
	assign idf_match = (i_instr[`MCJD_IDF_TEST_BIT] == i_core_id);
	assign idr_match = (i_instr[`MCJD_IDR_TEST_BIT] == i_core_id);

	always_comb begin
		next_cond = 1'b0;
		next_pc = seq_target;
		case (kind)
			MCJD_KIND_CREL: begin
				next_cond = cond_sel;
				if (cond_sel) begin
					next_pc = rel_target;
				end
			end
			MCJD_KIND_IDF: begin
				next_cond = idf_match;
				if (idf_match) begin
					next_pc = far_target;
				end
			end
			MCJD_KIND_IDR: begin
				next_cond = idr_match;
				if (idr_match) begin
					next_pc = rel_target;
				end
			end
			default: begin
				next_cond = 1'b0;
				next_pc = seq_target;
			end
		endcase
	end

	assign next_taken = next_cond && (kind != MCJD_KIND_NONE);

	// ======================================================================
	// Result registers
	// The pulse holds while the clock enable is low, so a stalled core keeps its result.
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_pc_load <= 1'b0;
		end else if (i_clk_en) begin
			o_pc_load <= i_instr_valid;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_next_pc <= {ADDR_W{`MCJD_PC_RST}};
		end else if (accept) begin
			o_next_pc <= next_pc;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			o_jump_taken <= 1'b0;
			o_decoded <= 1'b0;
			o_cond_met <= 1'b0;
		end else if (accept) begin
			o_jump_taken <= next_taken;
			o_decoded <= (kind != MCJD_KIND_NONE);
			o_cond_met <= next_cond;
		end
	end

	// ======================================================================
	// Checks
	// Opcodes are written out here on purpose, so a slip in the header shows up.
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	logic crel_req;
	logic idf_req;
	logic idr_req;
	logic other_req;
	assign crel_req = accept && (i_instr[15:11] == 5'h00);
	assign idf_req = accept && (i_instr[15:5] == 11'h1CC) && (i_instr[2:0] == 3'h5);
	assign idr_req = accept && (i_instr[15:6] == 10'h0BD);
	assign other_req = accept && !crel_req && !idf_req && !idr_req;

	sequence s_crel_true;
		crel_req && cond_sel;
	endsequence

	sequence s_loaded(logic [ADDR_W-1:0] tgt);
		o_pc_load && o_jump_taken && o_next_pc == tgt;
	endsequence

	sequence s_idle_cycle;
		i_clk_en && !i_instr_valid;
	endsequence

	sequence s_not_decoded;
		o_pc_load && !o_jump_taken && !o_decoded && !o_cond_met;
	endsequence

	crel_jump_a: assert property (s_crel_true |=> s_loaded($past(rel_target)))
		else $error("relative conditional jump did not load its target");

	rel_offset_a: assert property (crel_req |->
		ADDR_W'(rel_target - i_instr_addr) == ADDR_W'($signed(i_instr[4:0])))
		else $error("relative target not address plus signed offset");

	flag_test_a: assert property (crel_req && !i_instr[10] |->
		cond_sel == (i_flag[i_instr[8:5]] == i_instr[9]))
		else $error("flag low or high test mismatch");

	start_test_a: assert property (crel_req && i_instr[10:6] == 5'h12 |->
		cond_sel == (i_start == i_instr[5]))
		else $error("start input test mismatch");

	drain_high_a: assert property (crel_req && i_instr[10:5] == 6'h2D |->
		cond_sel == i_shortcut_drain[1])
		else $error("drain feedback high test mismatch");

	alu_done_a: assert property (crel_req && i_instr[10:5] == 6'h2F |->
		cond_sel == i_alu_done)
		else $error("arithmetic completion test mismatch");

	boost_low_a: assert property (crel_req && i_instr[10:5] == 6'h31 |->
		cond_sel != i_boost_voltage)
		else $error("boost low test mismatch");

	own_current_a: assert property (crel_req && i_instr[10:6] == 5'h1F |->
		cond_sel == (i_own_current_fb ^ i_instr[5]))
		else $error("own current feedback test mismatch");

	crel_decode_a: assert property (crel_req |=> o_decoded && o_pc_load)
		else $error("relative conditional jump not decoded");

	far_jump_a: assert property (idf_req && i_instr[4] == i_core_id |=>
		s_loaded($past(i_instr[3]) ? $past(i_jump_reg_one) : $past(i_jump_reg_zero)))
		else $error("far core jump did not load the jump register");

	core_id_a: assert property (idr_req && i_instr[5] != i_core_id |=>
		!o_jump_taken && !o_cond_met)
		else $error("core identity test taken for the wrong core");

	far_decode_a: assert property (accept && i_instr[15:5] == 11'h1CC &&
		i_instr[2:0] != 3'h5 |=> !o_decoded)
		else $error("far core jump decoded with a bad tail");

	rel_core_a: assert property (idr_req && i_instr[5] == i_core_id |=>
		s_loaded($past(rel_target)))
		else $error("relative core jump did not load its target");

	idr_decode_a: assert property (idr_req |=> o_decoded && o_pc_load)
		else $error("relative core jump not decoded");

	fall_through_a: assert property (accept && !next_cond |=>
		o_pc_load && !o_jump_taken && o_next_pc == $past(i_instr_addr) + ADDR_W'(1))
		else $error("failed test did not advance sequentially");

	// ======================================================================
	// Condition source and sequencing checks
	tc_test_a: assert property (crel_req && i_instr[10:7] == 4'h8 |->
		cond_sel == i_terminal_count[i_instr[6:5]])
		else $error("terminal count test mismatch");

	drain_low_a: assert property (crel_req && i_instr[10:5] == 6'h27 |->
		cond_sel == !i_shortcut_drain[1])
		else $error("drain feedback low test mismatch");

	source_low_a: assert property (crel_req && i_instr[10:5] == 6'h2B |->
		cond_sel == !i_shortcut_source[2])
		else $error("source feedback low test mismatch");

	boost_high_a: assert property (crel_req && i_instr[10:5] == 6'h30 |->
		cond_sel == i_boost_voltage)
		else $error("boost high test mismatch");

	current_high_a: assert property (crel_req && i_instr[10:5] == 6'h35 |->
		cond_sel == i_current_fb[3])
		else $error("current feedback high test mismatch");

	current_low_a: assert property (crel_req && i_instr[10:5] == 6'h3D |->
		cond_sel == !i_current_fb[5])
		else $error("current feedback low test mismatch");

	jreg_one_a: assert property (idf_req && i_instr[4] == i_core_id && i_instr[3] |=>
		o_next_pc == $past(i_jump_reg_one))
		else $error("far core jump ignored the register selector");

	idle_drop_a: assert property (s_idle_cycle |=> !o_pc_load)
		else $error("result pulse did not fall in an idle cycle");

	other_instr_a: assert property (other_req |=> s_not_decoded)
		else $error("non-jump instruction reported as a jump");

	hold_a: assert property (!i_clk_en |=> $stable(o_next_pc) && $stable(o_pc_load))
		else $error("state changed while clock enable low");
endmodule

`default_nettype wire

// ---- design/mcjd_pkg.sv ----
package mcjd_pkg;
	// Decoded instruction kind, one-hot.
	typedef enum logic [3:0] {
		MCJD_KIND_NONE = 4'b0001,
		MCJD_KIND_CREL = 4'b0010,
		MCJD_KIND_IDF = 4'b0100,
		MCJD_KIND_IDR = 4'b1000
	} mcjd_kind_t;

	typedef logic [5:0] mcjd_sel_t;
endpackage

// ---- dv/mcjd_decode_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcjd_cfg.svh"

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
	$display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module mcjd_decode_tb_top
	import mcjd_pkg::*;
;
	typedef struct packed {
		logic [15:0] ins;
		logic cid;
		logic [9:0] adr;
		logic [9:0] pc;
		logic tk;
		logic dc;
	} mcjd_row_t;

	localparam int AW = `MCJD_ADDR_W;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic clk_en = 1'b0;
	logic valid = 1'b0;
	logic core_id = 1'b0;
	logic [15:0] instr = 16'h0000;
	logic [AW-1:0] addr = '0;
	logic [AW-1:0] jr0 = 10'h3FF;
	logic [AW-1:0] jr1 = 10'h155;
	logic [35:0] src = 36'h0;
	logic pc_load, jump_taken, decoded, cond_met;
	logic [AW-1:0] next_pc;
	int err_total = 0;
	int tests_run = 0;

	// Far jumps use jump register 0 = 0x3FF and 1 = 0x155.
	mcjd_row_t rows [8] = '{
		'{16'h3985, 1'b0, 10'h010, 10'h3FF, 1'b1, 1'b1},
		'{16'h399D, 1'b1, 10'h010, 10'h155, 1'b1, 1'b1},
		'{16'h3995, 1'b0, 10'h010, 10'h011, 1'b0, 1'b1},
		'{16'h3984, 1'b0, 10'h010, 10'h011, 1'b0, 1'b0},
		'{16'h2F50, 1'b0, 10'h010, 10'h000, 1'b1, 1'b1},
		'{16'h2F6F, 1'b1, 10'h3FA, 10'h009, 1'b1, 1'b1},
		'{16'h2F6F, 1'b0, 10'h010, 10'h011, 1'b0, 1'b1},
		'{16'hFFFF, 1'b0, 10'h3FF, 10'h000, 1'b0, 1'b0}
	};

	mcjd_decode #(.ADDR_W(AW)) u_dut (
		.i_ref_clk(ref_clk), .i_nrst(nrst), .i_clk_en(clk_en), .i_instr_valid(valid),
		.i_instr(instr), .i_instr_addr(addr), .i_core_id(core_id),
		.i_jump_reg_zero(jr0), .i_jump_reg_one(jr1), .i_flag(src[15:0]),
		.i_terminal_count(src[19:16]), .i_start(src[20]), .i_shortcut_drain(src[23:21]),
		.i_shortcut_source(src[26:24]), .i_alu_done(src[27]), .i_boost_voltage(src[28]),
		.i_current_fb(src[34:29]), .i_own_current_fb(src[35]), .o_pc_load(pc_load),
		.o_next_pc(next_pc), .o_jump_taken(jump_taken), .o_decoded(decoded),
		.o_cond_met(cond_met)
	);

	always #2 ref_clk = ~ref_clk;

	// ==========================================================================
	// Reference model of the branch test select.
	function automatic logic cond_of(input int s, input logic [35:0] v);
		if (s < 16) return !v[s];
		if (s < 36) return (s == 36) ? 1'b0 : v[s-16];
		if (s == 36) return !v[20];
		if (s == 37) return v[20];
		if (s < 44) return !v[s-17];
		if (s < 47) return v[s-23];
		if (s == 47) return v[27];
		if (s == 48) return v[28];
		if (s == 49) return !v[28];
		if (s < 56) return v[s-21];
		if (s < 62) return !v[s-27];
		return (s == 62) ? v[35] : !v[35];
	endfunction

	task step(input logic [15:0] ins, input logic [AW-1:0] a, input logic cid,
		input logic [35:0] sv);
		@(negedge ref_clk);
		instr = ins;
		addr = a;
		core_id = cid;
		src = sv;
		valid = 1'b1;
		clk_en = 1'b1;
		@(posedge ref_clk);
		#1;
	endtask

	task conclude();
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ==========================================================================
	// Main sequence.
	initial begin
		logic [AW-1:0] a;
		logic [AW-1:0] e;
		logic [4:0] off;
		logic c;
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		for (int i = 0; i < 8; i++) begin
			step(rows[i].ins, rows[i].adr, rows[i].cid, 36'h0);
			`CHK(next_pc, rows[i].pc)
			`CHK({pc_load, jump_taken, decoded}, {1'b1, rows[i].tk, rows[i].dc})
		end
		// Back to back, every select code with the sources in one pattern and then inverted.
		for (int s = 0; s < 64; s++) begin
			for (int p = 0; p < 2; p++) begin
				off = 5'(s + p * 7);
				a = 10'(s * 16 + 8);
				c = cond_of(s, p ? ~36'h5A5C39E17 : 36'h5A5C39E17);
				e = c ? a + {{5{off[4]}}, off} : a + 10'h001;
				step({5'h00, 6'(s), off}, a, 1'(p), p ? ~36'h5A5C39E17 : 36'h5A5C39E17);
				`CHK(next_pc, e)
				`CHK({jump_taken, decoded, cond_met}, {c, 1'b1, c})
			end
		end
		@(negedge ref_clk);
		valid = 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK({pc_load, next_pc}, {1'b0, e})
		// A frozen clock enable must not let a new instruction through.
		@(negedge ref_clk);
		clk_en = 1'b0;
		valid = 1'b1;
		instr = 16'h3985;
		@(posedge ref_clk);
		#1;
		`CHK({pc_load, next_pc}, {1'b0, e})
		step(16'h3985, 10'h020, 1'b0, 36'h0);
		`CHK({pc_load, jump_taken, next_pc}, {2'b11, 10'h3FF})
		// A stalled core must keep seeing the last result, pulse included.
		@(negedge ref_clk);
		clk_en = 1'b0;
		valid = 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK({pc_load, jump_taken, next_pc}, {2'b11, 10'h3FF})
		// Reset must clear the results even while the clock enable is low.
		@(negedge ref_clk);
		nrst = 1'b0;
		@(posedge ref_clk);
		#1;
		`CHK({pc_load, jump_taken, decoded, cond_met, next_pc}, 14'h0000)
		// The first edge after release already takes an instruction.
		@(negedge ref_clk);
		nrst = 1'b1;
		clk_en = 1'b1;
		valid = 1'b1;
		core_id = 1'b0;
		instr = 16'h2F50;
		addr = 10'h030;
		@(posedge ref_clk);
		#1;
		`CHK({pc_load, jump_taken, decoded, next_pc}, {3'b111, 10'h020})
		conclude();
	end

	initial begin
		#20000;
		err_total++;
		conclude();
	end
endmodule
`default_nettype wire
